// >>> gf_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
module gf_delay_timer #(
	parameter int W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic start,
	input wire logic [W-1:0] limit,
	output logic done
);
	logic [W-1:0] count;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (!start) begin
			count <= '0;
		end else if (tick && count != limit) begin
			count <= count + 1'b1;
		end
	end
	assign done = start && (count == limit);
endmodule
`default_nettype wire

// >>> gf_diff_pickup.sv
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Pickup starts when displacement voltage exceeds its threshold.
// - Fault reported only after voltage persists for stabilising time.
// - Any change of fault conditions restarts the stabilising time.
// - Phase faulted if below low limit while other two exceed high.
// - Alarm needs unambiguous faulted phase unless phase check bypassed.
// - Zero-sequence-only wiring uses threshold only, skips phase checks.
// - Isolated neutral: direction from capacitive reactive component.
// - Coil grounded: direction from active component only.
// - Differential pickup needs forward fault at both ends.
// - Weak-current end: compare active amplitudes of both ends.
// - Direction found only above minimum direction current.
// - Record local and partner current amplitudes separately.
// - Alarm-only mode indicates detection and never trips.
// - Function inert unless global differential enable set.
// - Partner or link lost: local indications only, no pickup/trip.
// - Trip delayed by trip delay time after trip condition.
module gf_diff_pickup
	import gf_diff_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] displacement_voltage,
	input wire logic [15:0] phase_voltage_a,
	input wire logic [15:0] phase_voltage_b,
	input wire logic [15:0] phase_voltage_c,
	input wire logic [15:0] active_current,
	input wire logic active_sign,
	input wire logic [15:0] reactive_current,
	input wire logic reactive_capacitive,
	input wire logic [15:0] partner_active_current,
	input wire logic partner_forward,
	input wire logic partner_dir_valid,
	input wire logic partner_ok,
	output logic pickup,
	output logic fault_detected,
	output logic [2:0] faulted_phase,
	output logic direction_forward,
	output logic direction_valid,
	output logic diff_pickup,
	output logic alarm,
	output logic trip
);
	// ****************************************
	// Configuration registers
	// ****************************************
	logic [31:0] ctrl;
	logic [15:0] displacement_voltage_threshold;
	logic [15:0] faulted_phase_low_limit;
	logic [15:0] healthy_phase_high_limit;
	logic [15:0] direction_min_current;
	logic [15:0] detection_stabilize_time;
	logic [15:0] trip_delay_time;
	logic [15:0] local_active_current_record;
	logic [15:0] remote_active_current_record;

	wire differential_global_enable = ctrl[CTRL_EN_BIT];
	wire [1:0] function_mode_select = ctrl[CTRL_MODE_LSB+:2];
	wire neutral_treatment_select = ctrl[CTRL_NEUTRAL_BIT];
	wire v0_only = ctrl[CTRL_V0ONLY_BIT];
	wire phase_bypass = ctrl[CTRL_BYPASS_BIT];

	// ****************************************
	// APB slave, zero wait states
	// ****************************************
	wire apb_access = psel && penable;
	wire apb_wr = apb_access && pwrite;
	wire addr_ok = (paddr <= ADDR_RREC) && (paddr[1:0] == 2'h0);
	wire wr_ro = (paddr == ADDR_STAT) || (paddr == ADDR_LREC) ||
		(paddr == ADDR_RREC);
	// One strobe per register keeps each write block small
	wire wr_ctrl = apb_wr && (paddr == ADDR_CTRL);
	wire wr_vthr = apb_wr && (paddr == ADDR_VTHR);
	wire wr_vlim = apb_wr && (paddr == ADDR_VLIM);
	wire wr_imin = apb_wr && (paddr == ADDR_IMIN);
	wire wr_tdet = apb_wr && (paddr == ADDR_TDET);
	wire wr_ttrip = apb_wr && (paddr == ADDR_TTRIP);

	// Unused control bits read back as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= {26'h0, pwdata[5:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			displacement_voltage_threshold <= VTHR_RESET;
		end else if (wr_vthr) begin
			displacement_voltage_threshold <= pwdata[15:0];
		end
	end

	// Both limits share one word so software updates them together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			faulted_phase_low_limit <= VLOW_RESET;
			healthy_phase_high_limit <= VHIGH_RESET;
		end else if (wr_vlim) begin
			faulted_phase_low_limit <= pwdata[15:0];
			healthy_phase_high_limit <= pwdata[31:16];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			direction_min_current <= IMIN_RESET;
		end else if (wr_imin) begin
			direction_min_current <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			detection_stabilize_time <= TDET_RESET;
		end else if (wr_tdet) begin
			detection_stabilize_time <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_delay_time <= TTRIP_RESET;
		end else if (wr_ttrip) begin
			trip_delay_time <= pwdata[15:0];
		end
	end

	// ****************************************
	// Tick prescaler for the delay timers
	// ****************************************
	logic [31:0] tick_count;
	wire tick = (tick_count == 32'(TICK_DIV - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_count <= 32'h0000_0000;
		end else begin
			tick_count <= tick ? 32'h0000_0000 : tick_count + 32'h0000_0001;
		end
	end

	// ****************************************
	// Pickup and phase selection
	// ****************************************
	function automatic logic phase_sel(input logic [15:0] v,
		input logic [15:0] o1, input logic [15:0] o2,
		input logic [15:0] lo, input logic [15:0] hi);
		phase_sel = (v < lo) && (o1 > hi) && (o2 > hi);
	endfunction

	wire active = differential_global_enable &&
		(function_mode_select != MODE_OFF);
	wire next_pickup = active &&
		(displacement_voltage > displacement_voltage_threshold);
	wire [2:0] phase_hit = {
		phase_sel(phase_voltage_c, phase_voltage_a, phase_voltage_b,
			faulted_phase_low_limit, healthy_phase_high_limit),
		phase_sel(phase_voltage_b, phase_voltage_a, phase_voltage_c,
			faulted_phase_low_limit, healthy_phase_high_limit),
		phase_sel(phase_voltage_a, phase_voltage_b, phase_voltage_c,
			faulted_phase_low_limit, healthy_phase_high_limit)};
	wire phase_unique = (phase_hit == 3'h1) || (phase_hit == 3'h2) ||
		(phase_hit == 3'h4);
	// Zero-sequence-only wiring has no phase voltages to check
	wire phase_ok = v0_only || phase_bypass || phase_unique;
	wire [2:0] next_phase = v0_only ? 3'h0 : phase_hit;

	// ****************************************
	// Direction
	// ****************************************
	wire [15:0] dir_current = (neutral_treatment_select == NEUTRAL_COIL) ?
		active_current : reactive_current;
	wire dir_sign = (neutral_treatment_select == NEUTRAL_COIL) ?
		active_sign : reactive_capacitive;
	wire next_dir_valid = next_pickup &&
		(dir_current > direction_min_current);
	wire next_dir_fwd = next_dir_valid && dir_sign;

	// ****************************************
	// Stabilising timer, restarted on any change
	// ****************************************
	logic [4:0] cond_q;
	wire [4:0] cond_now = {next_dir_valid, next_dir_fwd, next_phase};
	wire cond_change = cond_now != cond_q;
	wire det_start = next_pickup && !cond_change;
	wire det_done;
	gf_delay_timer #(.W(16)) u_det (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.start(det_start),
		.limit(detection_stabilize_time),
		.done(det_done)
	);

	// ****************************************
	// Differential decision
	// ****************************************
	// A weak local end still picks up if its active current is larger
	wire amp_win = active_current > partner_active_current;
	wire both_fwd = (next_dir_fwd && partner_dir_valid && partner_forward) ||
		(!next_dir_valid && partner_dir_valid && partner_forward &&
		amp_win) ||
		(next_dir_fwd && !partner_dir_valid && amp_win);
	wire next_detected = det_done && phase_ok;
	wire next_diff = next_detected && partner_ok && both_fwd;
	wire trip_start = next_diff && (function_mode_select == MODE_ON);
	wire trip_done;
	gf_delay_timer #(.W(16)) u_trip (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.start(trip_start),
		.limit(trip_delay_time),
		.done(trip_done)
	);

	// ****************************************
	// Outputs and fault record
	// ****************************************
	// Snapshot of the conditions; any difference restarts the timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_q <= 5'h00;
		end else begin
			cond_q <= cond_now;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pickup <= 1'b0;
			fault_detected <= 1'b0;
			faulted_phase <= 3'h0;
		end else begin
			pickup <= next_pickup;
			fault_detected <= next_detected;
			faulted_phase <= next_detected ? next_phase : 3'h0;
		end
	end

	// Direction is only shown once the fault itself is confirmed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			direction_forward <= 1'b0;
			direction_valid <= 1'b0;
		end else begin
			direction_forward <= next_detected && next_dir_fwd;
			direction_valid <= next_detected && next_dir_valid;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diff_pickup <= 1'b0;
			alarm <= 1'b0;
			trip <= 1'b0;
		end else begin
			diff_pickup <= next_diff;
			alarm <= next_detected;
			trip <= trip_done && trip_start;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			local_active_current_record <= 16'h0000;
			remote_active_current_record <= 16'h0000;
		end else if (next_detected && !fault_detected) begin
			local_active_current_record <= dir_current;
			remote_active_current_record <= partner_active_current;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (paddr)
		ADDR_CTRL: rd_mux = ctrl;
		ADDR_VTHR: rd_mux = {16'h0, displacement_voltage_threshold};
		ADDR_VLIM: rd_mux = {healthy_phase_high_limit,
			faulted_phase_low_limit};
		ADDR_IMIN: rd_mux = {16'h0, direction_min_current};
		ADDR_TDET: rd_mux = {16'h0, detection_stabilize_time};
		ADDR_TTRIP: rd_mux = {16'h0, trip_delay_time};
		ADDR_STAT: rd_mux = {22'h0, trip, alarm, diff_pickup,
			direction_valid, direction_forward, faulted_phase,
			fault_detected, pickup};
		ADDR_LREC: rd_mux = {16'h0, local_active_current_record};
		ADDR_RREC: rd_mux = {16'h0, remote_active_current_record};
		default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Answer is prepared in setup so the access needs no wait state
	wire apb_setup = psel && !penable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= (apb_setup && !pwrite) ? rd_mux : prdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= apb_setup;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= apb_setup && (!addr_ok || (pwrite && wr_ro));
		end
	end
endmodule
`default_nettype wire

// >>> gf_diff_pickup_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module gf_diff_checker
	import gf_diff_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [15:0] displacement_voltage,
	input wire logic partner_ok,
	input wire logic pickup,
	input wire logic fault_detected,
	input wire logic [2:0] faulted_phase,
	input wire logic direction_forward,
	input wire logic direction_valid,
	input wire logic diff_pickup,
	input wire logic alarm,
	input wire logic trip
);
	// ****************************************
	// Shadow of the settings that gate outputs
	// ****************************************
	logic [5:0] ctrl;
	logic [15:0] vthr;
	wire wr = psel && penable && pwrite && pready;
	wire [1:0] mode = ctrl[CTRL_MODE_LSB +: 2];
	wire inert = !ctrl[CTRL_EN_BIT] || mode == MODE_OFF;
	wire alarm_mode = mode == MODE_ALARM;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET[5:0];
			vthr <= VTHR_RESET;
		end else if (wr && paddr == ADDR_CTRL) begin
			ctrl <= pwdata[5:0];
		end else if (wr && paddr == ADDR_VTHR) begin
			vthr <= pwdata[15:0];
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	// Pipeline depth of the outputs is one cycle, so gates must settle
	sequence s_inert;
		inert [*6];
	endsequence
	sequence s_link_down;
		!partner_ok [*6];
	endsequence
	a_apb_answer:
		assert property (s_setup |=> pready ##1 !pready)
		else $error("pready did not pulse once after setup");
	a_pickup_cause:
		assert property ($rose(pickup) |-> $past(displacement_voltage) > $past(vthr))
		else $error("pickup rose without voltage above threshold");
	a_fault_pickup:
		assert property (fault_detected |-> pickup || $past(pickup))
		else $error("fault reported without pickup");
	a_phase_unique:
		assert property ($onehot0(faulted_phase))
		else $error("more than one faulted phase");
	a_alarm_fault:
		assert property (alarm |-> fault_detected || $past(fault_detected))
		else $error("alarm without detected fault");
	a_dir_valid:
		assert property (direction_forward |-> direction_valid)
		else $error("forward direction while not resolved");
	a_alarm_notrip:
		assert property (alarm_mode [*6] |-> !trip)
		else $error("trip in alarm-only mode");
	a_inert_off:
		assert property (s_inert |-> !pickup && !fault_detected && !alarm && !trip)
		else $error("output active while function disabled");
	a_link_local:
		assert property (s_link_down |-> !diff_pickup && !trip)
		else $error("differential pickup without partner");
	a_trip_diff:
		assert property (trip |-> diff_pickup || $past(diff_pickup))
		else $error("trip without differential pickup");
endmodule
bind gf_diff_pickup gf_diff_checker checker_i (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .displacement_voltage,
	.partner_ok, .pickup, .fault_detected, .faulted_phase,
	.direction_forward, .direction_valid, .diff_pickup, .alarm, .trip);
`default_nettype wire

// >>> gf_diff_pickup_test.sv
`timescale 1ns/1ps
`default_nettype none
module gf_diff_pickup_test
	import gf_diff_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, pickup, fault_detected, direction_forward;
	logic direction_valid, diff_pickup, alarm, trip;
	logic [2:0] faulted_phase;
	logic [15:0] displacement_voltage = 16'h0, phase_voltage_a = 16'h0;
	logic [15:0] phase_voltage_b = 16'h0, phase_voltage_c = 16'h0;
	logic [15:0] active_current = 16'h0, reactive_current = 16'h0;
	logic active_sign = 1'b0, reactive_capacitive = 1'b0;
	logic [15:0] partner_active_current, remote_amp = 16'h003C;
	logic partner_forward, partner_dir_valid, partner_ok;
	logic link_up = 1'b1, remote_fwd = 1'b1, remote_resolved = 1'b1;
	logic slow = 1'b0;
	int fail_count = 0, checks_done = 0;
	always #12.5 pclk = ~pclk;
	gf_diff_pickup #(.TICK_DIV(4)) dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.displacement_voltage, .phase_voltage_a, .phase_voltage_b,
		.phase_voltage_c, .active_current, .active_sign, .reactive_current,
		.reactive_capacitive, .partner_active_current, .partner_forward,
		.partner_dir_valid, .partner_ok, .pickup, .fault_detected,
		.faulted_phase, .direction_forward, .direction_valid, .diff_pickup,
		.alarm, .trip);
	gf_partner_relay far_end (.pclk, .presetn, .link_up, .remote_fwd,
		.remote_resolved, .remote_amp, .slow, .partner_active_current,
		.partner_forward, .partner_dir_valid, .partner_ok);
	// ****************************************
	// Shared bus and compare tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, n >= 50}, 32'h0);
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		chk({31'h0, e}, {31'h0, xe});
	endtask
	task automatic line(input logic [15:0] v0, va, vb, vc, cur,
		input logic act, rea);
		displacement_voltage <= v0;
		phase_voltage_a <= va;
		phase_voltage_b <= vb;
		phase_voltage_c <= vc;
		active_current <= cur;
		reactive_current <= cur;
		active_sign <= act;
		reactive_capacitive <= rea;
		@(posedge pclk);
	endtask
	task automatic arm(input logic [31:0] c);
		line(16'h0, 16'h005A, 16'h005A, 16'h005A, 16'h0, 1'b0, 1'b0);
		repeat (8) @(posedge pclk);
		wr(ADDR_CTRL, c, 1'b0);
	endtask
	task automatic hit(input logic [15:0] vb, cur, input logic act, rea);
		line(16'h0064, 16'h0014, vb, 16'h005A, cur, act, rea);
	endtask
	// Outputs packed as fault, diff, alarm, trip; m selects those judged
	task automatic outs(input logic [3:0] x, input logic [3:0] m);
		repeat (40) @(posedge pclk);
		chk({28'h0, m & {fault_detected, diff_pickup, alarm, trip}},
			{28'h0, m & x});
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		rd(ADDR_CTRL, CTRL_RESET, 1'b0);
		rd(ADDR_VTHR, {16'h0, VTHR_RESET}, 1'b0);
		rd(ADDR_VLIM, {VHIGH_RESET, VLOW_RESET}, 1'b0);
		rd(ADDR_IMIN, {16'h0, IMIN_RESET}, 1'b0);
		rd(ADDR_TDET, {16'h0, TDET_RESET}, 1'b0);
		rd(ADDR_TTRIP, {16'h0, TTRIP_RESET}, 1'b0);
		rd(8'h24, 32'h0, 1'b1);
		wr(ADDR_STAT, 32'h3FF, 1'b1);
		wr(ADDR_TDET, 32'h2, 1'b0);
		wr(ADDR_TTRIP, 32'h3, 1'b0);
		rd(ADDR_TTRIP, 32'h3, 1'b0);
	endtask
	task automatic t_forward();
		arm(32'h3);
		hit(16'h005A, 16'h0064, 1'b1, 1'b1);
		repeat (2) @(posedge pclk);
		chk({31'h0, pickup}, 32'h1);
		chk({31'h0, fault_detected}, 32'h0);
		outs(4'hF, 4'hF);
		chk({29'h0, faulted_phase}, 32'h1);
		rd(ADDR_LREC, 32'h64, 1'b0);
		rd(ADDR_RREC, 32'h3C, 1'b0);
		hit(16'h005A, 16'h0064, 1'b0, 1'b0);
		outs(4'hA, 4'hF);
		hit(16'h005A, 16'h0064, 1'b1, 1'b1);
		repeat (4) @(posedge pclk);
		chk({31'h0, diff_pickup}, 32'h0);
		outs(4'hF, 4'hF);
	endtask
	task automatic t_modes();
		arm(32'h2);
		hit(16'h005A, 16'h0064, 1'b1, 1'b1);
		outs(4'h0, 4'hF);
		chk({31'h0, pickup}, 32'h0);
		arm(32'h5);
		hit(16'h005A, 16'h0064, 1'b1, 1'b1);
		outs(4'hA, 4'hB);
		link_up <= 1'b0;
		arm(32'h3);
		hit(16'h005A, 16'h0064, 1'b1, 1'b1);
		outs(4'hA, 4'hF);
		link_up <= 1'b1;
	endtask
	task automatic t_phase();
		arm(32'h3);
		hit(16'h0014, 16'h0064, 1'b1, 1'b1);
		outs(4'h0, 4'h3);
		arm(32'h13);
		hit(16'h0014, 16'h0064, 1'b1, 1'b1);
		outs(4'h2, 4'h2);
		arm(32'h23);
		hit(16'h0014, 16'h0064, 1'b1, 1'b1);
		outs(4'h2, 4'h2);
	endtask
	task automatic t_direction();
		slow <= 1'b1;
		arm(32'hB);
		hit(16'h005A, 16'h0064, 1'b1, 1'b0);
		outs(4'hF, 4'hF);
		hit(16'h005A, 16'h0064, 1'b0, 1'b1);
		outs(4'h0, 4'h4);
		chk({31'h0, direction_forward}, 32'h0);
		arm(32'h3);
		hit(16'h005A, 16'h0064, 1'b1, 1'b0);
		outs(4'h0, 4'h4);
		chk({31'h0, direction_forward}, 32'h0);
		hit(16'h005A, 16'h0014, 1'b1, 1'b1);
		outs(4'h0, 4'h4);
		chk({31'h0, direction_valid}, 32'h0);
		slow <= 1'b0;
	endtask
	task automatic t_weak();
		remote_resolved <= 1'b0;
		arm(32'h3);
		hit(16'h005A, 16'h0064, 1'b1, 1'b1);
		outs(4'h4, 4'h4);
		remote_amp <= 16'h00C8;
		outs(4'h0, 4'h4);
		remote_resolved <= 1'b1;
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_forward();
		t_modes();
		t_phase();
		t_direction();
		t_weak();
		give_verdict();
	end
	// The whole sequence needs about 800 cycles; twenty-five times that is a hang
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		give_verdict();
	end
endmodule
`default_nettype wire

// >>> gf_diff_pkg.sv
package gf_diff_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_VTHR = 8'h04;
	localparam logic [7:0] ADDR_VLIM = 8'h08;
	localparam logic [7:0] ADDR_IMIN = 8'h0C;
	localparam logic [7:0] ADDR_TDET = 8'h10;
	localparam logic [7:0] ADDR_TTRIP = 8'h14;
	localparam logic [7:0] ADDR_STAT = 8'h18;
	localparam logic [7:0] ADDR_LREC = 8'h1C;
	localparam logic [7:0] ADDR_RREC = 8'h20;
	// ****************************************
	// Control fields
	// ****************************************
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_NEUTRAL_BIT = 3;
	localparam int CTRL_V0ONLY_BIT = 4;
	localparam int CTRL_BYPASS_BIT = 5;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_ON = 2'h1;
	localparam logic [1:0] MODE_ALARM = 2'h2;
	localparam logic NEUTRAL_ISOLATED = 1'b0;
	localparam logic NEUTRAL_COIL = 1'b1;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [15:0] VTHR_RESET = 16'h0032;
	localparam logic [15:0] VLOW_RESET = 16'h0028;
	localparam logic [15:0] VHIGH_RESET = 16'h004B;
	localparam logic [15:0] IMIN_RESET = 16'h0032;
	localparam logic [15:0] TDET_RESET = 16'h0064;
	localparam logic [15:0] TTRIP_RESET = 16'h0000;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
endpackage

// >>> gf_partner_relay.sv
`timescale 1ns/1ps
`default_nettype none
module gf_partner_relay (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic link_up,
	input wire logic remote_fwd,
	input wire logic remote_resolved,
	input wire logic [15:0] remote_amp,
	input wire logic slow,
	output logic [15:0] partner_active_current,
	output logic partner_forward,
	output logic partner_dir_valid,
	output logic partner_ok
);
	// ****************************************
	// Far end of the protection link
	// ****************************************
	logic [17:0] held;
	logic [17:0] junk;
	wire [17:0] fresh = {remote_fwd, remote_resolved, remote_amp};
	// A dead link shows a changing pattern, never the last good data
	wire [17:0] shown = !partner_ok ? junk : (slow ? held : fresh);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held <= '0;
			junk <= '0;
			partner_ok <= 1'b0;
		end else begin
			held <= fresh;
			junk <= ~junk;
			partner_ok <= link_up;
		end
	end
	assign partner_forward = shown[17] && shown[16];
	assign partner_dir_valid = shown[16];
	assign partner_active_current = shown[15:0];
endmodule
`default_nettype wire
